// ### stepper_defs.svh
// Offsets, field positions, reset values and timing counts of one axis.
// Assumes inclusion by the filter and axis design files by bare name.
`ifndef STEPPER_DEFS_SVH
`define STEPPER_DEFS_SVH

// Host port addresses (two address lines)
`define ADDR_CMD 2'h0
`define ADDR_LOW 2'h1
`define ADDR_MID 2'h2
`define ADDR_HIGH 2'h3

// Command group codes in bits 7:6
`define GRP_START 2'h0
`define GRP_CTRL 2'h1
`define GRP_SEL 2'h2
`define GRP_OUT 2'h3

// Start-mode command bits
`define SM_INHIBIT_BIT 1
`define SM_HIGH_BIT 2
`define SM_STOP_BIT 3
`define SM_GO_BIT 4
`define SM_STOPINT_BIT 5

// Register indices selected by the register-select command
`define REG_COUNT 3'h0
`define REG_BASE 3'h1
`define REG_TOP 3'h2
`define REG_RATE 3'h3
`define REG_SCALE 3'h4
`define REG_RAMPPT 3'h5
`define REG_IDLE 3'h6
`define REG_STATUS 3'h7

// Reset values
`define RST_CMD 8'h00
`define RST_COUNT 24'h000000
`define RST_SPEED 13'h0001
`define RST_RATE 10'h002
`define RST_SCALE 10'h002
`define RST_RAMPPT 16'h0000

// Input filter: pulses shorter than this many clocks are dropped
`define FILTER_CYCLES 3'h4

// Model code shown in the fourth status word; the value is arbitrary
`define MODEL_CODE 8'h5a

`endif

// ### stepper_pkg.sv
// Types shared by the axis logic and its input filter.
// Assumes stepper_defs.svh is on the include path.
package stepper_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_EXT, ST_RUN, ST_DECEL}
    run_state_t;

  // Low six bits of the register-select command, D5 first
  typedef struct packed {
    logic ext_int_en;
    logic ramp_int_en;
    logic count_hold;
    logic [2:0] ptr;
  } reg_sel_t;

  // Low six bits of the output-mode command, D5 first
  typedef struct packed {
    logic monitor_ext;
    logic filter_on;
    logic speed_hold;
    logic phase_mask;
    logic pulse_off;
    logic pos_logic;
  } out_cfg_t;

  // Low six bits of the control-mode command, D5 first
  typedef struct packed {
    logic scurve;
    logic ots;
    logic neg_dir;
    logic preset_stop;
    logic sd_en;
    logic home_stop;
  } ctrl_t;

  // Filtered stop-type inputs, all active low
  typedef struct packed {
    logic ext_halt_n;
    logic home_n;
    logic limit_neg_n;
    logic limit_pos_n;
  } sensor_t;

endpackage : stepper_pkg

// ### input_filter.sv
// Optional glitch filter for the stop-type inputs.
// Assumes inputs already synchronous to mclk_in.
`timescale 1ns/10ps
`include "stepper_defs.svh"

module input_filter
  import stepper_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic filter_on_in,
  input wire sensor_t raw_in,
  output sensor_t clean_out
);

  logic [3:0] level;
  logic [3:0] next_level;
  logic [2:0] cnt [4];
  logic [2:0] next_cnt [4];

  // A change is accepted only after it has stood for the full count
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      next_cnt[i] = 3'h0;
      next_level[i] = level[i];
      if (!filter_on_in)
      begin
        next_level[i] = raw_in[i];
      end
      else if (raw_in[i] != level[i])
      begin
        next_cnt[i] = cnt[i] + 3'h1;
        if (cnt[i] + 3'h1 >= `FILTER_CYCLES)
        begin
          next_level[i] = raw_in[i];
          next_cnt[i] = 3'h0;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      level <= 4'hf;
      for (int i = 0; i < 4; i++)
      begin
        cnt[i] <= 3'h0;
      end
    end
    else if (clk_en_in)
    begin
      level <= next_level;
      cnt <= next_cnt;
    end
  end

  assign clean_out = sensor_t'(level);

endmodule : input_filter

// ### stepper_pulse_command_logic.sv
// Command, register and pulse logic of one stepper axis.
// Assumes host strobes synchronous to mclk_in; data pin split in three.
// Summary of operation
// - External start while start inhibited raises an interrupt if enabled.
// - Each interrupt clears only by writing its enable bit to zero.
// - Interrupt pin is OR of external-start, ramp-down and stop sources.
// - Register-select low three bits choose the register for data accesses.
// - Register-select D3 high freezes the down-counter.
// - Register-select D4 enables the ramp-down interrupt.
// - Output-mode D0 picks pulse polarity; pulses only on direction line.
// - Output-mode D1 stops pulses, freezes phases, ignores limit and home.
// - Output-mode D2 forces all four phase outputs low.
// - Output-mode D3 holds the present speed mid-ramp.
// - Output-mode D4 drops stop-type input pulses shorter than four clocks.
// - Output-mode D5 selects extended readback of registers and status.
// - Multi-byte writes commit to the register when the low byte lands.
// - The 24-bit counter decrements once per step, even with pulses off, unless held or already zero.
// - Selecting the counter copies it into a read snapshot.
// - Preset move stops when count reaches zero; count stays zero.
// - Start with zero count in preset mode stops at once, may interrupt.
// - Halted preset move keeps its remaining count for the next start.
// - Base speed is 13 bits; moves start at base speed; halts and immediate stops end at the present speed.
// - Ramp-down interrupt fires in a preset move once count falls below the ramp point.
`timescale 1ns/10ps
`include "stepper_defs.svh"

module stepper_pulse_command_logic
  import stepper_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic chip_sel_in_n,
  input wire logic rd_in_n,
  input wire logic wr_in_n,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  input wire logic ext_go_in_n,
  input wire logic ext_halt_in_n,
  input wire logic home_sensor_in_n,
  input wire logic [1:0] travel_limit_in_n,
  output logic [1:0] dir_pulse_out,
  output logic [3:0] phase_out,
  output logic running_out_n,
  output logic ots_out,
  output logic int_out_n
);

  logic [7:0] start_cmd, ctrl_cmd, sel_cmd, out_cmd;
  logic [7:0] next_start_cmd, next_ctrl_cmd, next_sel_cmd, next_out_cmd;
  logic [23:0] counter, snap, next_counter, next_snap;
  logic [12:0] base_speed, top_speed, speed;
  logic [12:0] next_base_speed, next_top_speed, next_speed;
  logic [9:0] ramp_rate, scale, prescale, ramp_cnt;
  logic [9:0] next_ramp_rate, next_scale, next_prescale, next_ramp_cnt;
  logic [15:0] ramp_point, next_ramp_point;
  logic [2:0] idle_pulses, next_idle_pulses;
  logic pref, next_pref;
  logic [7:0] stage_mid, stage_high, next_stage_mid, next_stage_high;
  logic [12:0] accum, next_accum;
  logic [1:0] phase, next_phase, next_dir_pulse;
  logic [3:0] next_phase_out;
  run_state_t state, next_state;
  logic ext_int, ramp_int, stop_int;
  logic next_ext_int, next_ramp_int, next_stop_int;
  logic wr_prev, rd_prev, go_prev;
  logic [7:0] next_data;

  reg_sel_t sel;
  out_cfg_t ocfg;
  ctrl_t ctrl;
  sensor_t sens;

  assign sel = reg_sel_t'(sel_cmd[5:0]);
  assign ocfg = out_cfg_t'(out_cmd[5:0]);
  assign ctrl = ctrl_t'(ctrl_cmd[5:0]);

  // Stop-type inputs pass the optional glitch filter
  input_filter u_filter (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .filter_on_in(ocfg.filter_on),
    .raw_in({ext_halt_in_n, home_sensor_in_n, travel_limit_in_n[0],
      travel_limit_in_n[1]}),
    .clean_out(sens)
  );

  // Two-phase excitation pattern for each of the four steps
  function automatic logic [3:0] excite(input logic [1:0] p);
    case (p)
      2'h0: excite = 4'h3;
      2'h1: excite = 4'h6;
      2'h2: excite = 4'hc;
      default: excite = 4'h9;
    endcase
  endfunction : excite

  // Readback byte for an address; the snapshot, not the live count, is read
  function automatic logic [7:0] read_byte(input logic [1:0] a);
    logic [7:0] st0, st1, st2, lo, mid, hi;
    st0 = {2'h0, state == ST_DECEL, state == ST_WAIT_EXT,
           ext_int, ramp_int, stop_int,
           state == ST_RUN || state == ST_DECEL};
    st1 = {4'h0, sens};
    st2 = {~int_out_n, ots_out, dir_pulse_out, phase_out};
    lo = st1;
    mid = 8'h00;
    hi = 8'h00;
    if (sel.ptr == `REG_COUNT)
    begin
      {hi, mid, lo} = snap;
    end
    else if (ocfg.monitor_ext)
    begin
      case (sel.ptr)
        `REG_BASE: {hi, mid, lo} = {start_cmd, 3'h0, base_speed};
        `REG_TOP: {hi, mid, lo} = {ctrl_cmd, 3'h0, top_speed};
        `REG_RATE: {hi, mid, lo} = {sel_cmd, 6'h00, ramp_rate};
        `REG_SCALE: {hi, mid, lo} = {out_cmd, 6'h00, scale};
        `REG_RAMPPT: {hi, mid, lo} = {7'h00, pref, ramp_point};
        `REG_IDLE: {hi, mid, lo} = {3'h0, speed, 5'h00, idle_pulses};
        default: {hi, mid, lo} = {`MODEL_CODE, st2, st1};
      endcase
    end
    case (a)
      `ADDR_CMD: read_byte = st0;
      `ADDR_LOW: read_byte = lo;
      `ADDR_MID: read_byte = mid;
      default: read_byte = hi;
    endcase
  endfunction : read_byte

  // Whole axis: host port, interrupts, ramp, pulse timing and counter
  always_comb
  begin
    logic wr_take, rd_take, go_fall, tick, step, stop_now, run;
    logic [13:0] sum;
    logic [12:0] target;
    logic [23:0] wval;
    wr_take = !chip_sel_in_n && !wr_in_n && !wr_prev;
    rd_take = !chip_sel_in_n && !rd_in_n && !rd_prev;
    go_fall = go_prev && !ext_go_in_n;
    wval = {stage_high, stage_mid, data_in};
    next_start_cmd = start_cmd;
    next_ctrl_cmd = ctrl_cmd;
    next_sel_cmd = sel_cmd;
    next_out_cmd = out_cmd;
    next_counter = counter;
    next_snap = snap;
    next_base_speed = base_speed;
    next_top_speed = top_speed;
    next_ramp_rate = ramp_rate;
    next_scale = scale;
    next_ramp_point = ramp_point;
    next_idle_pulses = idle_pulses;
    next_pref = pref;
    next_stage_mid = stage_mid;
    next_stage_high = stage_high;
    next_state = state;
    next_speed = speed;
    next_prescale = prescale;
    next_ramp_cnt = ramp_cnt;
    next_accum = accum;
    next_phase = phase;
    next_ext_int = ext_int;
    next_ramp_int = ramp_int;
    next_stop_int = stop_int;
    next_data = rd_take ? read_byte(addr_in) : data_out;
    run = (state == ST_RUN) || (state == ST_DECEL);
    stop_now = 1'b0;

    // Host writes: commands by group, data bytes staged until the low byte
    if (wr_take)
    begin
      case (addr_in)
        `ADDR_CMD:
        begin
          case (data_in[7:6])
            `GRP_START:
            begin
              next_start_cmd = data_in;
              if (!data_in[`SM_STOPINT_BIT])
              begin
                next_stop_int = 1'b0;
              end
            end
            `GRP_CTRL: next_ctrl_cmd = data_in;
            `GRP_SEL:
            begin
              next_sel_cmd = data_in;
              if (data_in[2:0] == `REG_COUNT)
              begin
                next_snap = counter;
              end
              if (!data_in[5])
              begin
                next_ext_int = 1'b0;
              end
              if (!data_in[4])
              begin
                next_ramp_int = 1'b0;
              end
            end
            default: next_out_cmd = data_in;
          endcase
        end
        `ADDR_MID: next_stage_mid = data_in;
        `ADDR_HIGH: next_stage_high = data_in;
        default:
        begin
          case (sel.ptr)
            `REG_COUNT: next_counter = wval;
            `REG_BASE: next_base_speed = wval[12:0];
            `REG_TOP: next_top_speed = wval[12:0];
            `REG_RATE: next_ramp_rate = wval[9:0];
            `REG_SCALE: next_scale = wval[9:0];
            `REG_RAMPPT: next_ramp_point = wval[15:0];
            `REG_IDLE: next_idle_pulses = wval[2:0];
            default: next_pref = wval[0];
          endcase
        end
      endcase
    end

    // Pulse timing: prescaler by scale, then rate accumulator by speed
    tick = prescale + 10'h001 >= scale;
    next_prescale = tick ? 10'h000 : prescale + 10'h001;
    sum = {1'b0, accum} + {1'b0, speed};
    step = run && tick && sum[13];
    if (run && tick)
    begin
      next_accum = sum[12:0];
    end
    if (step)
    begin
      if (!ocfg.pulse_off)
      begin
        next_phase = ctrl.neg_dir ? phase - 2'h1 : phase + 2'h1;
      end
      if (!sel.count_hold && counter != 24'h000000)
      begin
        next_counter = counter - 24'h000001;
      end
      if (ctrl.preset_stop && counter == 24'h000001)
      begin
        stop_now = 1'b1;
      end
    end

    // Ramp toward target; in a preset move the ramp-down point pulls the target to base
    target = start_cmd[`SM_HIGH_BIT] && state == ST_RUN ? top_speed
                                                         : base_speed;
    if (run && ctrl.preset_stop && {8'h00, ramp_point} > counter)
    begin
      target = base_speed;
      if (sel.ramp_int_en)
      begin
        next_ramp_int = 1'b1;
      end
    end
    if (run && !ocfg.speed_hold && tick)
    begin
      next_ramp_cnt = ramp_cnt + 10'h001;
      if (ramp_cnt + 10'h001 >= ramp_rate)
      begin
        next_ramp_cnt = 10'h000;
        if (speed < target)
        begin
          next_speed = speed + 13'h0001;
        end
        else if (speed > target)
        begin
          next_speed = speed - 13'h0001;
        end
      end
    end

    // External stops; limit and home are ignored while pulses are off
    if (run && (!sens.ext_halt_n ||
        (!ocfg.pulse_off && ((ctrl.home_stop && !sens.home_n) ||
         (ctrl.neg_dir ? !sens.limit_neg_n : !sens.limit_pos_n)))))
    begin
      stop_now = 1'b1;
    end
    if (state == ST_DECEL && speed <= base_speed)
    begin
      stop_now = 1'b1;
    end

    // Start and stop commands, external go, run state
    case (state)
      ST_IDLE, ST_WAIT_EXT:
      begin
        if (wr_take && addr_in == `ADDR_CMD &&
            data_in[7:6] == `GRP_START && data_in[`SM_GO_BIT] &&
            !data_in[`SM_STOP_BIT])
        begin
          next_state = data_in[`SM_INHIBIT_BIT] ? ST_WAIT_EXT : ST_RUN;
        end
        else if (state == ST_WAIT_EXT && go_fall)
        begin
          next_state = ST_RUN;
          if (sel.ext_int_en)
          begin
            next_ext_int = 1'b1;
          end
        end
        else if (wr_take && addr_in == `ADDR_CMD &&
                 data_in[7:6] == `GRP_START && data_in[`SM_STOP_BIT])
        begin
          next_state = ST_IDLE;
        end
        if (next_state == ST_RUN)
        begin
          next_speed = base_speed;
          next_accum = 13'h0000;
          next_ramp_cnt = 10'h000;
          if (ctrl.preset_stop && counter == 24'h000000)
          begin
            next_state = ST_IDLE;
            if (next_start_cmd[`SM_STOPINT_BIT])
            begin
              next_stop_int = 1'b1;
            end
          end
        end
      end
      ST_RUN, ST_DECEL:
      begin
        if (stop_now)
        begin
          next_state = ST_IDLE;
          if (start_cmd[`SM_STOPINT_BIT])
          begin
            next_stop_int = 1'b1;
          end
        end
        else if (wr_take && addr_in == `ADDR_CMD &&
                 data_in[7:6] == `GRP_START && data_in[`SM_STOP_BIT])
        begin
          next_state = data_in[`SM_HIGH_BIT] && state == ST_RUN ?
                       ST_DECEL : ST_IDLE;
          if (!data_in[`SM_HIGH_BIT] && data_in[`SM_STOPINT_BIT])
          begin
            next_stop_int = 1'b1;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase

    // Pin images; a pulse only ever shows on the line of the direction
    next_dir_pulse = {step && !ocfg.pulse_off && !ctrl.neg_dir,
                      step && !ocfg.pulse_off && ctrl.neg_dir};
    if (!ocfg.pos_logic)
    begin
      next_dir_pulse = ~next_dir_pulse;
    end
    next_phase_out = ocfg.phase_mask ? 4'h0 : excite(next_phase);
  end

  // State registers; the clock enable freezes everything
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      start_cmd <= `RST_CMD;
      ctrl_cmd <= `RST_CMD;
      sel_cmd <= `RST_CMD;
      out_cmd <= `RST_CMD;
      counter <= `RST_COUNT;
      snap <= `RST_COUNT;
      base_speed <= `RST_SPEED;
      top_speed <= `RST_SPEED;
      ramp_rate <= `RST_RATE;
      scale <= `RST_SCALE;
      ramp_point <= `RST_RAMPPT;
      idle_pulses <= 3'h0;
      pref <= 1'b0;
      stage_mid <= 8'h00;
      stage_high <= 8'h00;
      state <= ST_IDLE;
      speed <= `RST_SPEED;
      prescale <= 10'h000;
      ramp_cnt <= 10'h000;
      accum <= 13'h0000;
      phase <= 2'h0;
      ext_int <= 1'b0;
      ramp_int <= 1'b0;
      stop_int <= 1'b0;
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
      go_prev <= 1'b1;
      data_out <= 8'h00;
      dir_pulse_out <= 2'h3; // Negative logic idles high
      phase_out <= 4'h3;
      running_out_n <= 1'b1;
      ots_out <= 1'b0;
      int_out_n <= 1'b1;
    end
    else if (clk_en_in)
    begin
      start_cmd <= next_start_cmd;
      ctrl_cmd <= next_ctrl_cmd;
      sel_cmd <= next_sel_cmd;
      out_cmd <= next_out_cmd;
      counter <= next_counter;
      snap <= next_snap;
      base_speed <= next_base_speed;
      top_speed <= next_top_speed;
      ramp_rate <= next_ramp_rate;
      scale <= next_scale;
      ramp_point <= next_ramp_point;
      idle_pulses <= next_idle_pulses;
      pref <= next_pref;
      stage_mid <= next_stage_mid;
      stage_high <= next_stage_high;
      state <= next_state;
      speed <= next_speed;
      prescale <= next_prescale;
      ramp_cnt <= next_ramp_cnt;
      accum <= next_accum;
      phase <= next_phase;
      ext_int <= next_ext_int;
      ramp_int <= next_ramp_int;
      stop_int <= next_stop_int;
      wr_prev <= !chip_sel_in_n && !wr_in_n;
      rd_prev <= !chip_sel_in_n && !rd_in_n;
      go_prev <= ext_go_in_n;
      data_out <= next_data;
      dir_pulse_out <= next_dir_pulse;
      phase_out <= next_phase_out;
      running_out_n <= !(next_state == ST_RUN || next_state == ST_DECEL);
      ots_out <= next_ctrl_cmd[4];
      int_out_n <= !(next_ext_int || next_ramp_int || next_stop_int);
    end
  end

  // Bus drive follows the read strobe directly
  assign data_oe_out = !chip_sel_in_n && !rd_in_n;

endmodule : stepper_pulse_command_logic

// ### stepper_pulse_command_logic_props.sv
// Checker for one axis: host command tracking and pin relations.
// Assumes clk_en_in is held high while the checks run.
`timescale 1ns/10ps

module stepper_checker
  import stepper_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic chip_sel_in_n,
  input wire logic rd_in_n,
  input wire logic wr_in_n,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic [1:0] dir_pulse_out,
  input wire logic [3:0] phase_out,
  input wire logic ots_out,
  input wire logic int_out_n
);
  logic rd_act, wr_act, wr_prev, take, clr, ots_exp, next_ots_exp;
  logic [1:0] quiet, next_quiet;
  out_cfg_t cfg, next_cfg;

  // A write counts once, at the first edge of its strobe
  assign rd_act = !chip_sel_in_n && !rd_in_n;
  assign wr_act = !chip_sel_in_n && !wr_in_n;
  assign take = wr_act && !wr_prev && addr_in == 2'h0;
  assign clr = take && !data_in[6]; // Start or select group

  // Outputs get three cycles to follow any command
  always_comb
  begin
    next_quiet = (quiet == 2'h3) ? quiet : quiet + 2'h1;
    next_cfg = cfg;
    next_ots_exp = ots_exp;
    if (take)
      next_quiet = 2'h0;
    if (take && data_in[7:6] == 2'h3)
      next_cfg = out_cfg_t'(data_in[5:0]);
    if (take && data_in[7:6] == 2'h1)
      next_ots_exp = data_in[4];
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_prev <= 1'b0;
      quiet <= 2'h3;
      cfg <= '0;
      ots_exp <= 1'b0;
    end
    else
    begin
      wr_prev <= wr_act;
      quiet <= next_quiet;
      cfg <= next_cfg;
      ots_exp <= next_ots_exp;
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_settled;
    quiet == 2'h3;
  endsequence
  sequence s_read_held;
    rd_act [*3];
  endsequence

  property p_read_hold;
    s_read_held |-> $stable(data_out);
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read byte moved during a read");
  property p_mask;
    s_settled ##0 cfg.phase_mask |-> phase_out == 4'h0;
  endproperty
  a_mask: assert property (p_mask)
    else $error("phase lines not low while masked");
  property p_pos;
    s_settled ##0 cfg.pos_logic |-> dir_pulse_out != 2'h3;
  endproperty
  a_pos: assert property (p_pos)
    else $error("both lines high in positive logic");
  property p_neg;
    s_settled ##0 !cfg.pos_logic |-> dir_pulse_out != 2'h0;
  endproperty
  a_neg: assert property (p_neg)
    else $error("both lines low in negative logic");
  property p_off_idle;
    s_settled ##0 cfg.pulse_off |-> dir_pulse_out == {2{!cfg.pos_logic}};
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("pulse seen while pulses are off");
  property p_off_phase;
    s_settled ##1 cfg.pulse_off |-> $stable(phase_out);
  endproperty
  a_off_phase: assert property (p_off_phase)
    else $error("phase moved while pulses are off");
  property p_int_clear;
    $rose(int_out_n) |-> $past(clr) || $past(clr, 2);
  endproperty
  a_int_clear: assert property (p_int_clear)
    else $error("interrupt released without a clearing write");
  property p_ots;
    s_settled |-> ots_out == ots_exp;
  endproperty
  a_ots: assert property (p_ots)
    else $error("ots pin differs from last control command");
endmodule : stepper_checker

bind stepper_pulse_command_logic stepper_checker i_stepper_checker (
  .mclk_in, .rst_in, .chip_sel_in_n, .rd_in_n, .wr_in_n, .addr_in,
  .data_in, .data_out, .dir_pulse_out, .phase_out, .ots_out, .int_out_n
);

// ### host_model.sv
// Host processor model: byte writes and reads on the parallel bus.
// Assumes the bench calls its tasks; one clock shared with the axis.
`timescale 1ns/10ps

module host_model
(
  input wire logic mclk_in,
  input wire logic [7:0] rdata_in,
  output logic cs_out_n,
  output logic rd_out_n,
  output logic wr_out_n,
  output logic [1:0] addr_out,
  output logic [7:0] wdata_out
);
  // Bus idle and deselected from time zero
  initial
  begin
    cs_out_n = 1'b1;
    rd_out_n = 1'b1;
    wr_out_n = 1'b1;
    addr_out = 2'h0;
    wdata_out = 8'h00;
  end

  // Write taken at the first edge, then strobe high for a cycle
  task automatic wr_byte(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    cs_out_n <= 1'b0;
    wr_out_n <= 1'b0;
    addr_out <= a;
    wdata_out <= d;
    @(posedge mclk_in);
    cs_out_n <= 1'b1;
    wr_out_n <= 1'b1;
    wdata_out <= ~d; // Stale byte never looks valid
  endtask : wr_byte

  // Low byte last, since it commits the staged bytes
  task automatic wr24(input logic [23:0] v);
    wr_byte(2'h3, v[23:16]);
    wr_byte(2'h2, v[15:8]);
    wr_byte(2'h1, v[7:0]);
  endtask : wr24

  // Strobe held three edges so the held byte can be watched
  task automatic rd_byte(input logic [1:0] a, output logic [7:0] q);
    @(posedge mclk_in);
    cs_out_n <= 1'b0;
    rd_out_n <= 1'b0;
    addr_out <= a;
    repeat (3) @(posedge mclk_in);
    q = rdata_in;
    cs_out_n <= 1'b1;
    rd_out_n <= 1'b1;
  endtask : rd_byte
endmodule : host_model

// ### tb.sv
// Bench for one axis: host model, count model and pulse monitor.
// Assumes design, checker and host model are compiled before it.
`timescale 1ns/10ps

module tb
  import stepper_pkg::*;
;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ext_go_n = 1'b1;
  logic halt_n = 1'b1;
  logic cs_n, rd_n, wr_n, oe, run_n, ots, int_n;
  logic [1:0] addr, dir;
  logic [1:0] idle = 2'h3;
  logic [7:0] wdata, rdata, b;
  logic [3:0] phase;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int check_count = 0;
  int seed = 48;
  int pulse_cnt = 0;
  int model_cnt, seen, base;

  always #50 mclk_in = ~mclk_in;

  host_model i_host_model (.mclk_in(mclk_in), .rdata_in(rdata),
    .cs_out_n(cs_n), .rd_out_n(rd_n), .wr_out_n(wr_n),
    .addr_out(addr), .wdata_out(wdata));

  // Home and limit inputs stay released; clock enable held on
  stepper_pulse_command_logic i_stepper_pulse_command_logic (
    .mclk_in(mclk_in), .rst_in(rst_in), .clk_en_in(1'b1),
    .chip_sel_in_n(cs_n), .rd_in_n(rd_n), .wr_in_n(wr_n),
    .addr_in(addr), .data_in(wdata), .data_out(rdata),
    .data_oe_out(oe), .ext_go_in_n(ext_go_n), .ext_halt_in_n(halt_n),
    .home_sensor_in_n(1'b1), .travel_limit_in_n(2'h3),
    .dir_pulse_out(dir), .phase_out(phase), .running_out_n(run_n),
    .ots_out(ots), .int_out_n(int_n));

  // Any cycle with a line off its idle level is one pulse
  always @(posedge mclk_in)
    if (dir !== idle)
      pulse_cnt <= pulse_cnt + 1;

  task automatic check(input string what, input logic [23:0] e,
                       input logic [23:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic cmd(input logic [7:0] d);
    i_host_model.wr_byte(2'h0, d);
    if (d[7:6] == 2'h3)
      idle = d[0] ? 2'h0 : 2'h3;
  endtask : cmd

  task automatic load(input int n);
    cmd(8'h80);
    i_host_model.wr24(n[23:0]);
    model_cnt = n;
  endtask : load

  // Snapshot on select, then three bytes against the model
  task automatic read_cnt;
    cmd(8'h80);
    exp_q = {model_cnt[7:0], model_cnt[15:8], model_cnt[23:16]};
    for (int i = 1; i < 4; i++)
    begin
      i_host_model.rd_byte(2'(i), b);
      check("count byte", {16'h0, exp_q.pop_front()}, {16'h0, b});
    end
  endtask : read_cnt

  // Bounded wait for the axis to stop; pulses counted meanwhile
  task automatic run(input logic [7:0] st);
    base = pulse_cnt;
    cmd(st);
    @(posedge mclk_in);
    check("busy", !model_cnt, run_n);
    for (int i = 0; i < 3000 && (i < 4 || run_n !== 1'b1); i++)
      @(posedge mclk_in);
    repeat (3) @(posedge mclk_in);
    seen = pulse_cnt - base;
  endtask : run

  initial
  begin
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    check("rst", 24'h19d, {14'h0, oe, dir, phase, run_n, ots, int_n});
    i_host_model.rd_byte(2'h0, b);
    check("run_status", 24'h0, {16'h0, b});
    cmd(8'h81);
    i_host_model.wr24(24'h001fff);
    cmd(8'h54);
    for (int i = 0; i < 3; i++)
    begin
      load($random(seed) & 24'hffffff);
      read_cnt();
    end
    load(37);
    run(8'h10);
    check("pulses", 37, seen);
    model_cnt = 0;
    read_cnt();
    run(8'h30);
    check("zero run", 0, seen);
    check("stop int", 0, int_n);
    cmd(8'h00);
    repeat (3) @(posedge mclk_in);
    check("int clear", 1, int_n);
    load(40);
    cmd(8'h88);
    base = pulse_cnt;
    cmd(8'h10);
    repeat (60) @(posedge mclk_in);
    cmd(8'h08);
    repeat (4) @(posedge mclk_in);
    check("moved", 1, pulse_cnt > base);
    read_cnt();
    cmd(8'hd0);
    base = pulse_cnt;
    cmd(8'h10);
    halt_n <= 1'b0;
    repeat (3) @(posedge mclk_in);
    halt_n <= 1'b1;
    repeat (30) @(posedge mclk_in);
    check("glitch", 0, run_n);
    halt_n <= 1'b0;
    repeat (8) @(posedge mclk_in);
    halt_n <= 1'b1;
    repeat (4) @(posedge mclk_in);
    model_cnt = model_cnt - (pulse_cnt - base);
    read_cnt();
    run(8'h10);
    check("rest", model_cnt, seen);
    cmd(8'hc2);
    load(25);
    run(8'h30);
    check("off pulses", 0, seen);
    check("timer int", 0, int_n);
    model_cnt = 0;
    read_cnt();
    cmd(8'h00);
    cmd(8'hc1);
    load(9);
    run(8'h10);
    check("pos pulses", 9, seen);
    cmd(8'hc5);
    repeat (3) @(posedge mclk_in);
    check("phase", 0, phase);
    load(5);
    cmd(8'ha0);
    cmd(8'h12);
    repeat (4) @(posedge mclk_in);
    ext_go_n <= 1'b0;
    repeat (4) @(posedge mclk_in);
    ext_go_n <= 1'b1;
    repeat (40) @(posedge mclk_in);
    check("ext int", 0, int_n);
    cmd(8'h80);
    repeat (3) @(posedge mclk_in);
    check("ext clear", 1, int_n);
    cmd(8'h85);
    i_host_model.wr24(24'h000030);
    load(20);
    cmd(8'h90);
    run(8'h10);
    check("ramp int", 0, int_n);
    cmd(8'h80);
    cmd(8'he0);
    cmd(8'h81);
    i_host_model.rd_byte(2'h1, b);
    check("base low", 24'hff, {16'h0, b});
    cmd(8'hc0);
    i_host_model.rd_byte(2'h2, b);
    check("std mid", 0, {16'h0, b});
    report_and_stop();
  end

  // Watchdog: the sequence needs well under 30000 cycles
  initial
  begin
    #(100 * 30000);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb
